// ### bench/sdram_bank_precharge_refresh_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "sdram_defs.svh"
module sdram_link_assertions
  import sdram_pkg::*;
#(
  parameter int unsigned RFC_CYC = `RFC_CYC
)
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // Link
  input wire cmd_t cmd,
  input wire logic [1:0] bank,
  input wire logic [11:0] addr,
  input wire logic dqm,
  input wire logic rvalid
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  logic ap;
  logic [3:0] row_open;
  logic [7:0] quiet;
  logic [3:0] ap_left;
  logic [1:0] ap_bank;
  assign ap = addr[`PRE_SEL_BIT];

  // Rows as seen from the link alone
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      row_open <= 4'h0;
    else if (cmd == CMD_ACTIVE)
      row_open[bank] <= 1'b1;
    else if (cmd == CMD_PRECHARGE && ap)
      row_open <= 4'h0;
    else if (cmd == CMD_PRECHARGE || (cmd inside {CMD_READ, CMD_WRITE} && ap))
      row_open[bank] <= 1'b0;
  end

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      quiet <= 8'h00;
    else if (cmd == CMD_REFRESH)
      quiet <= 8'(RFC_CYC - 1);
    else if (quiet != 8'h00)
      quiet <= quiet - 8'h01;
  end

  // Lower bound only: burst, recovery and precharge
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      ap_left <= 4'h0;
      ap_bank <= 2'h0;
    end
    else if (cmd inside {CMD_READ, CMD_WRITE} && ap)
    begin
      ap_left <= 4'hb;
      ap_bank <= bank;
    end
    else if (ap_left != 4'h0)
      ap_left <= ap_left - 4'h1;
  end

  sequence s_rd4;
    cmd == CMD_READ ##1 (cmd == CMD_NOP)[*3];
  endsequence
  property p_rd_lat;
    cmd == CMD_READ |-> ##2 rvalid;
  endproperty
  property p_rd_burst;
    s_rd4 |-> rvalid[*3];
  endproperty
  property p_dqm_lead;
    cmd == CMD_WRITE && rvalid |-> $past(dqm, 2) && $past(dqm);
  endproperty
  property p_ref_quiet;
    quiet != 8'h00 |-> cmd == CMD_NOP;
  endproperty
  property p_ref_closed;
    cmd == CMD_REFRESH |-> row_open == 4'h0;
  endproperty
  property p_pre_gap;
    cmd == CMD_PRECHARGE |=> (cmd != CMD_REFRESH)[*4];
  endproperty
  property p_acc_open;
    cmd inside {CMD_READ, CMD_WRITE} |-> row_open[bank];
  endproperty
  property p_act_closed;
    cmd == CMD_ACTIVE |-> !row_open[bank];
  endproperty
  property p_ap_wait;
    ap_left != 4'h0 |-> !(cmd == CMD_ACTIVE && bank == ap_bank);
  endproperty

  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  a_rd_burst: assert property (p_rd_burst) else $error("read burst short");
  a_dqm_lead: assert property (p_dqm_lead) else $error("no mask lead");
  a_ref_quiet: assert property (p_ref_quiet) else $error("command in refresh");
  a_ref_closed: assert property (p_ref_closed) else $error("refresh with open row");
  a_pre_gap: assert property (p_pre_gap) else $error("refresh too soon");
  a_acc_open: assert property (p_acc_open) else $error("access to idle bank");
  a_act_closed: assert property (p_act_closed) else $error("active to open bank");
  a_ap_wait: assert property (p_ap_wait) else $error("bank reused early");
endmodule
`default_nettype wire

// ### bench/sdram_bank_precharge_refresh_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "sdram_defs.svh"
module sdram_bank_precharge_refresh_tb
  import sdram_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic en = 1'b1;
  logic req_valid = 1'b0;
  cmd_t req_cmd = CMD_NOP;
  logic [1:0] req_bank = 2'h0;
  logic [11:0] req_addr = 12'h000;
  logic [15:0] req_wdata = 16'h0000;
  logic req_dqm = 1'b0;
  logic req_ready, rsp_valid, array_we, array_refresh, refresh_busy, cmd_error;
  logic [15:0] rsp_rdata, array_wdata, array_rdata;
  logic [1:0] array_bank;
  logic [8:0] array_col;
  logic [11:0] refresh_row;
  logic [3:0] bank_open;
  logic [15:0] rsp_mem[64];
  logic [15:0] we_last[4];
  int we_cnt[4];
  int rsp_n = 0;
  int ref_cnt = 0;
  int err_seen = 0;
  int cyc = 0;
  int err_total = 0;
  int check_count = 0;

  sdram_link_if #(.DW(16)) link();
  // Array answers with its own address, so read data is predictable
  assign array_rdata = {array_bank, 5'h00, array_col};

  sdram_bank_device i_sdram_bank_device (.CLK_SYS(clk), .NRST(nrst), .EN(en),
    .LINK(link.device), .ARRAY_WE(array_we), .ARRAY_RE(), .ARRAY_BANK(array_bank),
    .ARRAY_COL(array_col), .ARRAY_WDATA(array_wdata), .ARRAY_RDATA(array_rdata),
    .ARRAY_REFRESH(array_refresh), .REFRESH_ROW(refresh_row), .BANK_OPEN(bank_open),
    .REFRESH_BUSY(refresh_busy), .CMD_ERROR(cmd_error));
  sdram_bank_ctrl i_sdram_bank_ctrl (.CLK_SYS(clk), .NRST(nrst), .EN(en), .LINK(link.ctrl),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_CMD(req_cmd), .REQ_BANK(req_bank),
    .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_DQM(req_dqm),
    .RSP_RDATA(rsp_rdata), .RSP_VALID(rsp_valid));
  sdram_link_assertions #(.RFC_CYC(`RFC_CYC)) i_sdram_link_assertions (.CLK_SYS(clk),
    .NRST(nrst), .cmd(link.cmd), .bank(link.bank), .addr(link.addr), .dqm(link.dqm),
    .rvalid(link.rvalid));

  always #2 clk = ~clk;

  // Non-blocking so tasks at the same edge see settled counts
  always @(posedge clk)
  begin
    cyc++;
    if (rsp_valid === 1'b1)
    begin
      rsp_mem[rsp_n % 64] <= rsp_rdata;
      rsp_n <= rsp_n + 1;
    end
    if (array_we === 1'b1)
    begin
      we_cnt[array_bank] <= we_cnt[array_bank] + 1;
      we_last[array_bank] <= array_wdata;
    end
    if (array_refresh === 1'b1)
      ref_cnt <= ref_cnt + 1;
    if (cmd_error !== 1'b0 && nrst)
      err_seen <= err_seen + 1;
    if (cyc == 5000)
    begin
      err_total++;
      test_done;
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] rd_exp(input logic [1:0] b, input logic [8:0] c);
    return {b, 5'h00, c};
  endfunction

  // Holds the request until taken; caller releases with idle
  task automatic req(input cmd_t c, input logic [1:0] b, input logic [11:0] a,
    input logic [15:0] d = 16'h0000);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bank <= b;
    req_addr <= a;
    req_wdata <= d;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 300);
    @(posedge clk);
    if (n >= 300)
      chk(16'h0000, 16'h0001);
  endtask

  task automatic idle(input int n);
    req_valid <= 1'b0;
    req_cmd <= CMD_NOP;
    repeat (n) @(posedge clk);
  endtask

  task automatic pre_all;
    req(CMD_PRECHARGE, 2'h0, 12'h400);
    idle(8);
  endtask

  task automatic t_banks;
    req(CMD_ACTIVE, 2'h2, 12'h001);
    req(CMD_ACTIVE, 2'h3, 12'h002);
    req(CMD_PRECHARGE, 2'h2, 12'h000);
    idle(8);
    chk(16'(bank_open), 16'h0008);
    req(CMD_PRECHARGE, 2'h1, 12'h400);
    idle(8);
    chk(16'(bank_open), 16'h0000);
    req(CMD_ACTIVE, 2'h3, 12'h003);
    idle(4);
    chk(16'(bank_open), 16'h0008);
    pre_all;
  endtask

  task automatic t_read;
    int r0;
    req(CMD_ACTIVE, 2'h0, 12'h055);
    r0 = rsp_n;
    req(CMD_READ, 2'h0, 12'h006);
    idle(12);
    chk(16'(rsp_n - r0), 16'h0004);
    for (int i = 0; i < 4; i++)
      chk(rsp_mem[(r0 + i) % 64], rd_exp(2'h0, 9'h004 + 9'((i + 2) % 4)));
    chk(16'(bank_open), 16'h0001);
    pre_all;
  endtask

  // Auto precharge access on bank 0 cut by an access to bank 1
  task automatic t_cut(input cmd_t first, input cmd_t second);
    int r0;
    int w0;
    int w1;
    int k;
    req(CMD_ACTIVE, 2'h0, 12'h010);
    req(CMD_ACTIVE, 2'h1, 12'h020);
    idle(12);
    r0 = rsp_n;
    w0 = we_cnt[0];
    w1 = we_cnt[1];
    k = (first == CMD_READ) ? 1 : 0;
    req(first, 2'h0, 12'h400, 16'h1234);
    req(second, 2'h1, 12'h000, 16'h5678);
    idle(60);
    chk(16'(bank_open), 16'h0002);
    if (first == CMD_READ)
      chk(rsp_mem[r0 % 64], rd_exp(2'h0, 9'h000));
    if (first == CMD_WRITE)
    begin
      chk(16'(we_cnt[0] - w0), 16'h0001);
      chk(we_last[0], 16'h1234);
    end
    if (second == CMD_READ)
    begin
      chk(16'(rsp_n - r0), 16'(4 + k));
      chk(rsp_mem[(r0 + k) % 64], rd_exp(2'h1, 9'h000));
    end
    if (second == CMD_WRITE)
      chk(16'(we_cnt[1] - w1), 16'h0004);
    pre_all;
  endtask

  task automatic t_wbm;
    int w0;
    int r0;
    req(CMD_LOAD_MODE, 2'h0, 12'h222);
    req(CMD_ACTIVE, 2'h0, 12'h000);
    w0 = we_cnt[0];
    r0 = rsp_n;
    req(CMD_WRITE, 2'h0, 12'h000, 16'hbeef);
    req(CMD_READ, 2'h0, 12'h000);
    idle(12);
    chk(16'(we_cnt[0] - w0), 16'h0001);
    chk(16'(rsp_n - r0), 16'h0004);
    pre_all;
    req(CMD_LOAD_MODE, 2'h0, 12'h227);
    req(CMD_ACTIVE, 2'h0, 12'h000);
    req(CMD_WRITE, 2'h0, 12'h400);
    idle(40);
    chk(16'(bank_open), 16'h0001);
    pre_all;
    req(CMD_LOAD_MODE, 2'h0, 12'h022);
    idle(2);
  endtask

  task automatic t_refresh;
    int f0;
    pre_all;
    f0 = ref_cnt;
    req(CMD_REFRESH, 2'h3, 12'hfff);
    idle(3);
    chk(16'(refresh_busy), 16'h0001);
    chk(16'(ref_cnt - f0), 16'h0001);
    req(CMD_ACTIVE, 2'h0, 12'h000);
    idle(4);
    chk(16'(bank_open), 16'h0001);
    chk(16'(refresh_row), 16'(ref_cnt));
    pre_all;
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    chk(16'(bank_open), 16'h0000);
    idle(2);
    t_banks;
    t_read;
    t_cut(CMD_READ, CMD_READ);
    t_cut(CMD_READ, CMD_WRITE);
    t_cut(CMD_WRITE, CMD_READ);
    t_cut(CMD_WRITE, CMD_WRITE);
    t_wbm;
    t_refresh;
    chk(16'(err_seen), 16'h0000);
    test_done;
  end
endmodule
`default_nettype wire

// ### hw/sdram_bank_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "sdram_defs.svh"
module sdram_bank_ctrl
  import sdram_pkg::*;
#(
  parameter int unsigned DW = 16,
  parameter int unsigned RP_CYC = `RP_CYC,
  parameter int unsigned WR_CYC = `WR_CYC,
  parameter int unsigned RAS_CYC = `RAS_CYC,
  parameter int unsigned RFC_CYC = `RFC_CYC
)
(
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic EN,
  // Link to the device
  sdram_link_if.ctrl LINK,
  // Requests
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire cmd_t REQ_CMD,
  input wire logic [1:0] REQ_BANK,
  input wire logic [`ADDR_W-1:0] REQ_ADDR,
  input wire logic [DW-1:0] REQ_WDATA,
  input wire logic REQ_DQM,
  // Read answers
  output logic [DW-1:0] RSP_RDATA,
  output logic RSP_VALID
);
  // Worst case window of an auto precharge access, never too short
  localparam int unsigned AP_HOLD = `MAX_BL + `MAX_CL + WR_CYC + RAS_CYC + RP_CYC;
  localparam int unsigned RD_SPAN = `MAX_BL + `MAX_CL;

  if (AP_HOLD > 255 || RFC_CYC < 1 || RFC_CYC > 255 || RP_CYC < 1)
  begin : g_bad_cfg
    $error("controller counts must fit eight bits");
  end

  logic [3:0] row_open;
  logic [7:0] busy [4];
  logic [7:0] ref_left;
  logic [3:0] rd_left;
  logic [1:0] mask_cnt;
  logic any_busy;
  logic ok;
  logic take;
  logic mask_go;

  always_comb
  begin
    any_busy = 1'b0;
    for (int b = 0; b < 4; b++)
      any_busy = any_busy || busy[b] != 8'h00;
  end

  always_comb
  begin
    case (REQ_CMD)
      CMD_ACTIVE: ok = !row_open[REQ_BANK] && busy[REQ_BANK] == 8'h00;
      CMD_READ: ok = row_open[REQ_BANK];
      CMD_WRITE: ok = row_open[REQ_BANK] && (rd_left == 4'h0 || mask_cnt == 2'h1);
      CMD_PRECHARGE: ok = REQ_ADDR[`PRE_SEL_BIT] ? !any_busy : busy[REQ_BANK] == 8'h00;
      CMD_REFRESH: ok = row_open == 4'h0 && !any_busy;
      CMD_LOAD_MODE: ok = row_open == 4'h0 && !any_busy;
      default: ok = 1'b1;
    endcase
  end

  assign REQ_READY = EN && ref_left == 8'h00 && ok;
  assign take = REQ_VALID && REQ_READY;
  // Mask two cycles ahead of a write that meets read data in flight
  assign mask_go = EN && REQ_VALID && REQ_CMD == CMD_WRITE && row_open[REQ_BANK] &&
                   rd_left != 4'h0 && mask_cnt == 2'h0;

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      mask_cnt <= 2'h0;
      rd_left <= 4'h0;
    end
    else if (EN)
    begin
      if (mask_go)
        mask_cnt <= 2'h2;
      else if (mask_cnt == 2'h2)
        mask_cnt <= 2'h1;
      else if (mask_cnt == 2'h1 && (take || rd_left == 4'h0))
        mask_cnt <= 2'h0;
      if (take && REQ_CMD == CMD_READ)
        rd_left <= 4'(RD_SPAN);
      else if (rd_left != 4'h0)
        rd_left <= rd_left - 4'h1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      row_open <= 4'h0;
      ref_left <= 8'h00;
      for (int b = 0; b < 4; b++)
        busy[b] <= 8'h00;
    end
    else if (EN)
    begin
      if (take && REQ_CMD == CMD_REFRESH)
        ref_left <= 8'(RFC_CYC - 1);
      else if (ref_left != 8'h00)
        ref_left <= ref_left - 8'h01;
      for (int b = 0; b < 4; b++)
      begin
        if (take && REQ_CMD == CMD_ACTIVE && REQ_BANK == 2'(b))
          row_open[b] <= 1'b1;
        else if (take && (REQ_CMD == CMD_READ || REQ_CMD == CMD_WRITE) &&
                 REQ_ADDR[`PRE_SEL_BIT] && REQ_BANK == 2'(b))
        begin
          row_open[b] <= 1'b0;
          busy[b] <= 8'(AP_HOLD);
        end
        else if (take && REQ_CMD == CMD_PRECHARGE &&
                 (REQ_ADDR[`PRE_SEL_BIT] || REQ_BANK == 2'(b)))
        begin
          row_open[b] <= 1'b0;
          busy[b] <= 8'(RP_CYC - 1);
        end
        else if (busy[b] != 8'h00)
          busy[b] <= busy[b] - 8'h01;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      LINK.cmd <= CMD_NOP;
      LINK.bank <= 2'h0;
      LINK.addr <= '0;
      LINK.wdata <= '0;
      LINK.dqm <= 1'b0;
      RSP_RDATA <= '0;
      RSP_VALID <= 1'b0;
    end
    else if (EN)
    begin
      LINK.cmd <= take ? REQ_CMD : CMD_NOP;
      LINK.bank <= REQ_BANK;
      LINK.addr <= REQ_ADDR;
      LINK.wdata <= REQ_WDATA;
      LINK.dqm <= take ? REQ_DQM : (mask_go || mask_cnt != 2'h0);
      RSP_RDATA <= LINK.rdata;
      RSP_VALID <= LINK.rvalid;
    end
  end
endmodule
`default_nettype wire

// ### hw/sdram_bank_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "sdram_defs.svh"
module sdram_bank_device
  import sdram_pkg::*;
#(
  parameter int unsigned DW = 16,
  parameter int unsigned RP_CYC = `RP_CYC,
  parameter int unsigned WR_CYC = `WR_CYC,
  parameter int unsigned RAS_CYC = `RAS_CYC,
  parameter int unsigned RFC_CYC = `RFC_CYC,
  parameter int unsigned MAX_CL = `MAX_CL
)
(
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic EN,
  // Link to the controller
  sdram_link_if.device LINK,
  // Array side
  output logic ARRAY_WE,
  output logic ARRAY_RE,
  output logic [1:0] ARRAY_BANK,
  output logic [`COL_W-1:0] ARRAY_COL,
  output logic [DW-1:0] ARRAY_WDATA,
  input wire logic [DW-1:0] ARRAY_RDATA,
  output logic ARRAY_REFRESH,
  output logic [`ADDR_W-1:0] REFRESH_ROW,
  // Status
  output logic [3:0] BANK_OPEN,
  output logic REFRESH_BUSY,
  output logic CMD_ERROR
);
  localparam int unsigned PIPE = MAX_CL - 1;

  if (MAX_CL < 2 || RFC_CYC < 1 || RFC_CYC > 255)
  begin : g_bad_cfg
    $error("device needs MAX_CL >= 2 and RFC_CYC in 1..255");
  end

  logic [`MR_W-1:0] mode;
  logic [7:0] ref_left;
  bank_state_t bank_state [4];
  logic [3:0] bank_ready;
  logic [3:0] bank_act;
  logic [3:0] open_row;
  logic [3:0] close_now;
  logic [3:0] close_auto;
  logic [3:0] close_wr;

  logic bst_on;
  logic bst_wr;
  logic bst_cont;
  logic bst_ap;
  logic [1:0] bst_bank;
  logic [`COL_W-1:0] bst_col;
  logic [`COL_W-1:0] bst_mask;
  logic [3:0] bst_left;

  logic [PIPE-1:0] pipe_v;
  logic [DW-1:0] pipe_d [PIPE];

  logic is_rd;
  logic is_wr;
  logic pre_sel;
  logic act_ok;
  logic acc_ok;
  logic pre_ok;
  logic ref_ok;
  logic lmr_ok;
  logic [2:0] bl_code;
  logic [2:0] cl;
  logic cont;
  logic single_wr;
  logic new_cont;
  logic [3:0] new_len;
  logic [`COL_W-1:0] new_mask;
  logic ap_eff;
  logic new_single;
  logic bst_last;
  logic old_end;
  logic bst_kill;
  logic elem_on;
  logic elem_wr;
  logic [1:0] elem_bank;
  logic [`COL_W-1:0] elem_col;
  logic [`COL_W-1:0] cur_mask;
  logic [`COL_W-1:0] next_col;
  int unsigned ins;

  assign is_rd = LINK.cmd == CMD_READ;
  assign is_wr = LINK.cmd == CMD_WRITE;
  assign pre_sel = LINK.addr[`PRE_SEL_BIT];
  assign REFRESH_BUSY = ref_left != 8'h00;

  // Nothing but idle commands are honoured while a refresh runs
  assign act_ok = EN && !REFRESH_BUSY && LINK.cmd == CMD_ACTIVE && bank_ready[LINK.bank];
  assign acc_ok = EN && !REFRESH_BUSY && (is_rd || is_wr) && bank_act[LINK.bank];
  assign pre_ok = EN && !REFRESH_BUSY && LINK.cmd == CMD_PRECHARGE;
  assign ref_ok = EN && !REFRESH_BUSY && LINK.cmd == CMD_REFRESH && (&bank_ready);
  assign lmr_ok = EN && !REFRESH_BUSY && LINK.cmd == CMD_LOAD_MODE && (&bank_ready);

  assign bl_code = mode[`MR_BL_LSB +: 3];
  assign cl = mode[`MR_CL_LSB +: 3];
  assign cont = bl_code == `BL_CONT_CODE;
  assign single_wr = is_wr && mode[`MR_WBM_BIT];
  assign new_cont = cont && !single_wr;
  // Reserved length codes fall back to one column
  assign new_len = (single_wr || bl_code[2]) ? 4'h1 : 4'(4'h1 << bl_code[1:0]);
  assign new_mask = new_cont ? {`COL_W{1'b1}} : `COL_W'(new_len - 4'h1);
  assign ap_eff = pre_sel && !cont;
  assign new_single = acc_ok && !new_cont && new_len == 4'h1;

  assign bst_last = bst_on && !bst_cont && bst_left == 4'h1;
  // An auto precharge burst ends by running out or by a new access
  assign old_end = bst_on && bst_ap && (acc_ok || bst_last);
  assign bst_kill = pre_ok && (pre_sel || LINK.bank == bst_bank);

  assign elem_on = acc_ok || (bst_on && !bst_kill);
  assign elem_wr = acc_ok ? is_wr : bst_wr;
  assign elem_bank = acc_ok ? LINK.bank : bst_bank;
  assign elem_col = acc_ok ? LINK.addr[`COL_W-1:0] : bst_col;
  assign cur_mask = acc_ok ? new_mask : bst_mask;
  assign next_col = (elem_col & ~cur_mask) | ((elem_col + `COL_W'(1)) & cur_mask);

  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      open_row[b] = act_ok && LINK.bank == 2'(b);
      close_now[b] = pre_ok && (pre_sel || LINK.bank == 2'(b));
      close_auto[b] = (old_end && !bst_wr && bst_bank == 2'(b)) ||
                      (new_single && ap_eff && is_rd && LINK.bank == 2'(b));
      close_wr[b] = (old_end && bst_wr && bst_bank == 2'(b)) ||
                    (new_single && ap_eff && is_wr && LINK.bank == 2'(b));
    end
  end

  for (genvar b = 0; b < 4; b++)
  begin : g_bank
    sdram_bank_timer #(
      .RP_CYC(RP_CYC),
      .WR_CYC(WR_CYC),
      .RAS_CYC(RAS_CYC)
    ) u_timer (
      .clk(CLK_SYS),
      .nrst(NRST),
      .en(EN),
      .open_row(open_row[b]),
      .close_now(close_now[b]),
      .close_auto(close_auto[b]),
      .close_after_wr(close_wr[b]),
      .state(bank_state[b]),
      .ready(bank_ready[b])
    );
    assign bank_act[b] = bank_state[b] == BANK_ACTIVE;
    assign BANK_OPEN[b] = bank_state[b] == BANK_ACTIVE || bank_state[b] == BANK_CLOSING;
  end

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      mode <= `MR_RESET;
    else if (lmr_ok)
      mode <= LINK.addr;
  end

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      CMD_ERROR <= 1'b0;
    else if (EN)
      CMD_ERROR <= LINK.cmd != CMD_NOP && !(act_ok || acc_ok || pre_ok || ref_ok || lmr_ok);
  end

  // Refresh rows come from an internal counter; the address is unused
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      ref_left <= 8'h00;
      ARRAY_REFRESH <= 1'b0;
      REFRESH_ROW <= '0;
    end
    else if (EN)
    begin
      ARRAY_REFRESH <= ref_ok;
      if (ref_ok)
        ref_left <= 8'(RFC_CYC - 1);
      else if (ref_left != 8'h00)
        ref_left <= ref_left - 8'h01;
      if (ARRAY_REFRESH)
        REFRESH_ROW <= REFRESH_ROW + `ADDR_W'(1);
    end
  end

  // A new access always wins the column slot, so the interrupted
  // write's last element is the one of the cycle before
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      bst_on <= 1'b0;
      bst_wr <= 1'b0;
      bst_cont <= 1'b0;
      bst_ap <= 1'b0;
      bst_bank <= 2'h0;
      bst_col <= '0;
      bst_mask <= '0;
      bst_left <= 4'h0;
    end
    else if (EN)
    begin
      if (acc_ok)
      begin
        bst_on <= new_cont || new_len != 4'h1;
        bst_wr <= is_wr;
        bst_cont <= new_cont;
        bst_ap <= ap_eff;
        bst_bank <= LINK.bank;
        bst_col <= next_col;
        bst_mask <= new_mask;
        bst_left <= new_len - 4'h1;
      end
      else if (bst_kill || bst_last)
        bst_on <= 1'b0;
      else if (bst_on)
      begin
        bst_col <= next_col;
        bst_left <= bst_left - 4'h1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      ARRAY_WE <= 1'b0;
      ARRAY_RE <= 1'b0;
      ARRAY_BANK <= 2'h0;
      ARRAY_COL <= '0;
      ARRAY_WDATA <= '0;
    end
    else if (EN)
    begin
      ARRAY_WE <= elem_on && elem_wr && !LINK.dqm;
      ARRAY_RE <= elem_on && !elem_wr;
      ARRAY_BANK <= elem_bank;
      ARRAY_COL <= elem_col;
      ARRAY_WDATA <= LINK.wdata;
    end
  end

  // Read data enter the pipe at a depth set by the latency field
  always_comb
  begin
    ins = 0;
    if (cl > 3'h2)
      ins = (int'(cl) - 2 < PIPE) ? int'(cl) - 2 : PIPE - 1;
  end

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      pipe_v <= '0;
      for (int i = 0; i < PIPE; i++)
        pipe_d[i] <= '0;
    end
    else if (EN)
    begin
      for (int i = 0; i < PIPE; i++)
      begin
        if (i == ins)
        begin
          pipe_v[i] <= ARRAY_RE;
          pipe_d[i] <= ARRAY_RDATA;
        end
        else if (i + 1 < PIPE)
        begin
          pipe_v[i] <= pipe_v[i+1];
          pipe_d[i] <= pipe_d[i+1];
        end
        else
          pipe_v[i] <= 1'b0;
      end
    end
  end

  assign LINK.rvalid = pipe_v[0];
  assign LINK.rdata = pipe_d[0];
endmodule
`default_nettype wire

// ### hw/sdram_bank_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "sdram_defs.svh"
module sdram_bank_timer
  import sdram_pkg::*;
#(
  parameter int unsigned RP_CYC = `RP_CYC,
  parameter int unsigned WR_CYC = `WR_CYC,
  parameter int unsigned RAS_CYC = `RAS_CYC
)
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  // Events
  input wire logic open_row,
  input wire logic close_now,
  input wire logic close_auto,
  input wire logic close_after_wr,
  // State
  output bank_state_t state,
  output logic ready
);
  logic [7:0] ras_left;
  logic [7:0] wr_left;
  logic [7:0] rp_left;

  if (RP_CYC < 1 || RP_CYC > 255 || WR_CYC < 1 || WR_CYC > 255 || RAS_CYC < 1 || RAS_CYC > 255)
  begin : g_bad_timing
    $error("bank timer counts must lie in 1..255");
  end

  assign ready = (state == BANK_IDLE) || (state == BANK_PRECHARGING && rp_left == 8'h00);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ras_left <= 8'h00;
    else if (en)
    begin
      if (open_row)
        ras_left <= 8'(RAS_CYC - 1);
      else if (ras_left != 8'h00)
        ras_left <= ras_left - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= BANK_IDLE;
      wr_left <= 8'h00;
      rp_left <= 8'h00;
    end
    else if (en)
    begin
      unique case (state)
        BANK_IDLE, BANK_PRECHARGING:
        begin
          if (rp_left != 8'h00)
            rp_left <= rp_left - 8'h01;
          else if (open_row)
            state <= BANK_ACTIVE;
          else
            state <= BANK_IDLE;
        end
        BANK_ACTIVE:
        begin
          if (close_now)
          begin
            state <= BANK_PRECHARGING;
            rp_left <= 8'(RP_CYC - 1);
          end
          else if (close_after_wr)
          begin
            state <= BANK_CLOSING;
            wr_left <= 8'(WR_CYC - 1);
          end
          else if (close_auto && ras_left == 8'h00)
          begin
            state <= BANK_PRECHARGING;
            rp_left <= 8'(RP_CYC - 1);
          end
          else if (close_auto)
          begin
            state <= BANK_CLOSING;
            wr_left <= 8'h00;
          end
        end
        BANK_CLOSING:
        begin
          // Held off by recovery and by the least row active time
          if (wr_left != 8'h00)
            wr_left <= wr_left - 8'h01;
          if (wr_left == 8'h00 && ras_left == 8'h00)
          begin
            state <= BANK_PRECHARGING;
            rp_left <= 8'(RP_CYC - 1);
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### shared/sdram_defs.svh
`ifndef SDRAM_DEFS_SVH
`define SDRAM_DEFS_SVH

// Clock period in picoseconds
`define CLK_PERIOD_PS 4000

// Timing figures in nanoseconds
`define T_RP_NS 18
`define T_WR_NS 12
`define T_RAS_NS 42
`define T_RFC_NS 72

// Least times round up to whole clock cycles
`define NS_MIN_CYC(t) ((((t) * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RP_CYC `NS_MIN_CYC(`T_RP_NS)
`define WR_CYC `NS_MIN_CYC(`T_WR_NS)
`define RAS_CYC `NS_MIN_CYC(`T_RAS_NS)
`define RFC_CYC `NS_MIN_CYC(`T_RFC_NS)

// Mode register layout
`define MR_W 12
`define MR_BL_LSB 0
`define MR_CL_LSB 4
`define MR_WBM_BIT 9
`define MR_RESET 12'h022
`define BL_CONT_CODE 3'h7

// Address bit that selects all banks or auto precharge
`define PRE_SEL_BIT 10
`define ADDR_W 12
`define COL_W 9

// Burst and latency limits
`define MAX_BL 8
`define MAX_CL 3

`endif

// ### shared/sdram_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sdram_link_if
  import sdram_pkg::*;
#(
  parameter int unsigned DW = 16
);
  cmd_t cmd;
  logic [1:0] bank;
  logic [11:0] addr;
  logic [DW-1:0] wdata;
  logic dqm;
  logic [DW-1:0] rdata;
  logic rvalid;

  modport device
  (
    input cmd,
    input bank,
    input addr,
    input wdata,
    input dqm,
    output rdata,
    output rvalid
  );

  modport ctrl
  (
    output cmd,
    output bank,
    output addr,
    output wdata,
    output dqm,
    input rdata,
    input rvalid
  );
endinterface
`default_nettype wire

// ### shared/sdram_pkg.sv
package sdram_pkg;

  typedef enum logic [2:0]
  {
    CMD_NOP = 3'h0,
    CMD_ACTIVE = 3'h1,
    CMD_READ = 3'h2,
    CMD_WRITE = 3'h3,
    CMD_PRECHARGE = 3'h4,
    CMD_REFRESH = 3'h5,
    CMD_LOAD_MODE = 3'h6
  } cmd_t;

  // Gray order: idle, active, closing, precharging
  typedef enum logic [1:0]
  {
    BANK_IDLE = 2'h0,
    BANK_ACTIVE = 2'h1,
    BANK_CLOSING = 2'h3,
    BANK_PRECHARGING = 2'h2
  } bank_state_t;

endpackage
